/* File: design/rrsd_params.svh */
/*
  holds: opcode, field and clock-count constants for the return/rotate/shift decoder.
  assumes: included by bare name; definitions only.
*/
`ifndef RRSD_PARAMS_SVH
`define RRSD_PARAMS_SVH

`define RRSD_OP_RET_NEAR 8'hC3
`define RRSD_OP_RET_NEAR_IMM 8'hC2
`define RRSD_OP_RET_FAR_IMM 8'hCA
`define RRSD_OP_RET_FAR 8'hCB
`define RRSD_OP_FLAGS_AH 8'h9E
`define RRSD_OP_ESCAPE 8'h0F
`define RRSD_OP2_RESTORE_SEG 8'h79
`define RRSD_OP2_RESTORE_LDT 8'h78
`define RRSD_OP2_RESTORE_TASK 8'h7D
`define RRSD_OP2_LEAVE_SMM 8'hAA
`define RRSD_SHIFT_HI_ONE_CNT 4'hD
`define RRSD_SHIFT_HI_IMM 4'hC
`define RRSD_SHIFT_LO_ONE_IMM 3'h0
`define RRSD_SHIFT_LO_CNT 3'h1
`define RRSD_REG_ROL 3'h0
`define RRSD_REG_ROR 3'h1
`define RRSD_REG_SAL 3'h4
`define RRSD_REG_SAR 3'h7
`define RRSD_FLAG_KEEP_MASK 8'h2A

`define RRSD_CLK_RET_NEAR_REAL 7'h0A
`define RRSD_CLK_RET_IMM_REAL 7'h0D
`define RRSD_CLK_RET_PROT 7'h1A
`define RRSD_CLK_RET_FAR_IMM_MISS 7'h1B
`define RRSD_CLK_RET_PRIV_MISS 7'h48
`define RRSD_CLK_RET_PRIV_HIT 7'h3C
`define RRSD_CLK_SH_REG 7'h02
`define RRSD_CLK_SH_MEM 7'h04
`define RRSD_CLK_SH_CNT_REG 7'h03
`define RRSD_CLK_SH_CNT_MEM 7'h05
`define RRSD_CLK_SH_MISS 7'h06
`define RRSD_CLK_SH_CNT_MISS 7'h07
`define RRSD_CLK_RESTORE 7'h0E
`define RRSD_CLK_LEAVE_SMM 7'h4C
`define RRSD_CLK_FLAGS_AH 7'h02
`endif

/* File: design/rrsd_pkg.sv */
/*
  holds: types shared by the decoder.
  assumes: nothing.
*/
package rrsd_pkg;
  typedef enum logic [3:0] {
    RRSD_OP_NONE = 4'h0,
    RRSD_OP_RETURN = 4'h1,
    RRSD_OP_ROL = 4'h2,
    RRSD_OP_ROR = 4'h3,
    RRSD_OP_SAL = 4'h4,
    RRSD_OP_SAR = 4'h5,
    RRSD_OP_RST_SEG = 4'h6,
    RRSD_OP_RST_LDT = 4'h7,
    RRSD_OP_RST_TASK = 4'h8,
    RRSD_OP_LEAVE_SMM = 4'h9,
    RRSD_OP_FLAGS_AH = 4'hA
  } rrsd_op_t;
  typedef enum logic [1:0] {
    RRSD_CNT_NONE = 2'h0,
    RRSD_CNT_ONE = 2'h1,
    RRSD_CNT_REG = 2'h2,
    RRSD_CNT_IMM = 2'h3
  } rrsd_cnt_t;
endpackage : rrsd_pkg

/* File: design/rrsd_busy_counter.sv */
/*
  holds: down counter that holds the decoder busy for one cycle fewer than an instruction's clock count.
  assumes: load only when idle.
*/
`timescale 1ns/100ps
`default_nettype none
`include "rrsd_params.svh"
module rrsd_busy_counter (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // load
  input wire logic load,
  input wire logic [6:0] count,
  // state
  output logic busy,
  output logic done
);
  logic [6:0] cnt_reg;
  logic [6:0] cnt_next;
  always_comb begin
    cnt_next = cnt_reg;
    if (load) begin
      cnt_next = count - 7'h01;
    end else if (cnt_reg != 7'h00) begin
      cnt_next = cnt_reg - 7'h01;
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_reg <= 7'h00;
    end else begin
      cnt_reg <= cnt_next;
    end
  end
  assign busy = (cnt_reg != 7'h00);
  // done marks the last cycle of an instruction longer than one clock
  assign done = (cnt_reg == 7'h01);
endmodule : rrsd_busy_counter
`default_nettype wire

/* File: design/rrsd_decoder.sv */
/*
  holds: decoder and clock-count timing for returns, rotates/shifts, restores,
  leave-management-mode and flag load from accumulator high byte.
  assumes: fetch unit presents whole instructions (opcode, second byte, modrm, imm16)
  with a valid strobe synchronous to CLK, and holds them while BUSY is high.
*/
`timescale 1ns/100ps
`default_nettype none
`include "rrsd_params.svh"
module rrsd_decoder (
  // clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // instruction from fetch
  input wire logic INSN_VALID,
  input wire logic [7:0] INSN_OP,
  input wire logic [7:0] INSN_OP2,
  input wire logic [7:0] INSN_MODRM,
  input wire logic [15:0] INSN_IMM16,
  // machine state
  input wire logic PROT_MODE,
  input wire logic CACHE_MISS,
  input wire logic PRIV_CHANGE,
  input wire logic SMM_ACTIVE,
  input wire logic [7:0] ACC_HIGH_BYTE,
  input wire logic [7:0] FLAGS_IN,
  input wire logic [31:0] STACK_PTR_IN,
  // decode results
  output logic INSN_READY,
  output var rrsd_pkg::rrsd_op_t OP_CLASS,
  output var rrsd_pkg::rrsd_cnt_t COUNT_SRC,
  output logic MEM_OPERAND,
  output logic [2:0] SEG_SELECT,
  output logic ILLEGAL,
  output logic BUSY,
  output logic DONE,
  output logic [6:0] CLOCKS,
  // state updates
  output logic FLAGS_WE,
  output logic [7:0] FLAGS_OUT,
  output logic SP_ADJ_WE,
  output logic [31:0] STACK_PTR_OUT,
  output logic SMM_EXIT
);
  rrsd_pkg::rrsd_op_t op_reg, op_next;
  rrsd_pkg::rrsd_cnt_t cnt_src_reg, cnt_src_next;
  logic mem_reg, mem_next;
  logic [2:0] seg_reg, seg_next;
  logic ill_reg, ill_next;
  logic [6:0] clk_reg, clk_next;
  logic fwe_reg, fwe_next;
  logic [7:0] flags_reg, flags_next;
  logic spwe_reg, spwe_next;
  logic [31:0] sp_reg, sp_next;
  logic smx_reg, smx_next;
  logic take;
  logic busy_w;
  logic done_w;

  // shift timing shared by all four shift operations
  function automatic logic [6:0] shift_clocks(input logic by_cnt, input logic mem,
                                             input logic miss);
    if (mem && miss) begin
      shift_clocks = by_cnt ? `RRSD_CLK_SH_CNT_MISS : `RRSD_CLK_SH_MISS;
    end else if (by_cnt) begin
      shift_clocks = mem ? `RRSD_CLK_SH_CNT_MEM : `RRSD_CLK_SH_CNT_REG;
    end else begin
      shift_clocks = mem ? `RRSD_CLK_SH_MEM : `RRSD_CLK_SH_REG;
    end
  endfunction : shift_clocks

  assign INSN_READY = !busy_w;
  assign take = INSN_VALID && !busy_w;

  always_comb begin
    op_next = op_reg;
    cnt_src_next = cnt_src_reg;
    mem_next = mem_reg;
    seg_next = seg_reg;
    ill_next = ill_reg;
    clk_next = clk_reg;
    fwe_next = 1'b0;
    flags_next = flags_reg;
    spwe_next = 1'b0;
    sp_next = sp_reg;
    smx_next = 1'b0;
    if (take) begin
      op_next = rrsd_pkg::RRSD_OP_NONE;
      cnt_src_next = rrsd_pkg::RRSD_CNT_NONE;
      mem_next = (INSN_MODRM[7:6] != 2'h3);
      seg_next = 3'h0;
      ill_next = 1'b0;
      clk_next = 7'h01;
      if (INSN_OP == `RRSD_OP_RET_NEAR) begin
        op_next = rrsd_pkg::RRSD_OP_RETURN;
        clk_next = PROT_MODE ? `RRSD_CLK_RET_PROT : `RRSD_CLK_RET_NEAR_REAL;
      end else if (INSN_OP == `RRSD_OP_RET_NEAR_IMM) begin
        op_next = rrsd_pkg::RRSD_OP_RETURN;
        clk_next = PROT_MODE ? `RRSD_CLK_RET_PROT : `RRSD_CLK_RET_IMM_REAL;
        spwe_next = 1'b1;
        sp_next = STACK_PTR_IN + {16'h0000, INSN_IMM16};
      end else if (INSN_OP == `RRSD_OP_RET_FAR_IMM || INSN_OP == `RRSD_OP_RET_FAR) begin
        op_next = rrsd_pkg::RRSD_OP_RETURN;
        if (PROT_MODE && PRIV_CHANGE) begin
          clk_next = CACHE_MISS ? `RRSD_CLK_RET_PRIV_MISS : `RRSD_CLK_RET_PRIV_HIT;
        end else if (PROT_MODE) begin
          clk_next = CACHE_MISS ? `RRSD_CLK_RET_FAR_IMM_MISS : `RRSD_CLK_RET_PROT;
        end else begin
          clk_next = `RRSD_CLK_RET_IMM_REAL;
        end
        if (INSN_OP == `RRSD_OP_RET_FAR_IMM) begin
          spwe_next = 1'b1;
          sp_next = STACK_PTR_IN + {16'h0000, INSN_IMM16};
        end
      end else if (INSN_OP == `RRSD_OP_FLAGS_AH) begin
        op_next = rrsd_pkg::RRSD_OP_FLAGS_AH;
        clk_next = `RRSD_CLK_FLAGS_AH;
        fwe_next = 1'b1;
        flags_next = (FLAGS_IN & `RRSD_FLAG_KEEP_MASK)
                     | (ACC_HIGH_BYTE & ~`RRSD_FLAG_KEEP_MASK);
      end else if ((INSN_OP[7:4] == `RRSD_SHIFT_HI_ONE_CNT
                    && (INSN_OP[3:1] == `RRSD_SHIFT_LO_ONE_IMM
                        || INSN_OP[3:1] == `RRSD_SHIFT_LO_CNT))
                   || (INSN_OP[7:4] == `RRSD_SHIFT_HI_IMM
                       && INSN_OP[3:1] == `RRSD_SHIFT_LO_ONE_IMM)) begin
        if (INSN_OP[7:4] == `RRSD_SHIFT_HI_IMM) begin
          cnt_src_next = rrsd_pkg::RRSD_CNT_IMM;
        end else if (INSN_OP[3:1] == `RRSD_SHIFT_LO_CNT) begin
          cnt_src_next = rrsd_pkg::RRSD_CNT_REG;
        end else begin
          cnt_src_next = rrsd_pkg::RRSD_CNT_ONE;
        end
        clk_next = shift_clocks(INSN_OP[7:4] == `RRSD_SHIFT_HI_ONE_CNT
                                && INSN_OP[3:1] == `RRSD_SHIFT_LO_CNT,
                                INSN_MODRM[7:6] != 2'h3, CACHE_MISS);
        unique case (INSN_MODRM[5:3])
          `RRSD_REG_ROL: op_next = rrsd_pkg::RRSD_OP_ROL;
          `RRSD_REG_ROR: op_next = rrsd_pkg::RRSD_OP_ROR;
          `RRSD_REG_SAL: op_next = rrsd_pkg::RRSD_OP_SAL;
          `RRSD_REG_SAR: op_next = rrsd_pkg::RRSD_OP_SAR;
          default: begin
            op_next = rrsd_pkg::RRSD_OP_NONE;
            cnt_src_next = rrsd_pkg::RRSD_CNT_NONE;
            clk_next = 7'h01;
          end
        endcase
      end else if (INSN_OP == `RRSD_OP_ESCAPE) begin
        if (INSN_OP2 == `RRSD_OP2_RESTORE_SEG) begin
          op_next = rrsd_pkg::RRSD_OP_RST_SEG;
          seg_next = INSN_MODRM[5:3];
          clk_next = `RRSD_CLK_RESTORE;
          ill_next = !SMM_ACTIVE;
        end else if (INSN_OP2 == `RRSD_OP2_RESTORE_LDT) begin
          op_next = rrsd_pkg::RRSD_OP_RST_LDT;
          clk_next = `RRSD_CLK_RESTORE;
        end else if (INSN_OP2 == `RRSD_OP2_RESTORE_TASK) begin
          op_next = rrsd_pkg::RRSD_OP_RST_TASK;
          clk_next = `RRSD_CLK_RESTORE;
        end else if (INSN_OP2 == `RRSD_OP2_LEAVE_SMM) begin
          op_next = rrsd_pkg::RRSD_OP_LEAVE_SMM;
          clk_next = `RRSD_CLK_LEAVE_SMM;
          smx_next = 1'b1;
        end
      end
      // an illegal restore takes one cycle so the fault is raised promptly
      if (ill_next) begin
        clk_next = 7'h01;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      op_reg <= rrsd_pkg::RRSD_OP_NONE;
      cnt_src_reg <= rrsd_pkg::RRSD_CNT_NONE;
      mem_reg <= 1'b0;
      seg_reg <= 3'h0;
      ill_reg <= 1'b0;
      clk_reg <= 7'h00;
      fwe_reg <= 1'b0;
      flags_reg <= 8'h00;
      spwe_reg <= 1'b0;
      sp_reg <= 32'h00000000;
      smx_reg <= 1'b0;
    end else begin
      op_reg <= op_next;
      cnt_src_reg <= cnt_src_next;
      mem_reg <= mem_next;
      seg_reg <= seg_next;
      ill_reg <= ill_next;
      clk_reg <= clk_next;
      fwe_reg <= fwe_next;
      flags_reg <= flags_next;
      spwe_reg <= spwe_next;
      sp_reg <= sp_next;
      smx_reg <= smx_next;
    end
  end

  rrsd_busy_counter u_busy (
    .clk(CLK),
    .rst_n(RST_N),
    .load(take),
    .count(clk_next),
    .busy(busy_w),
    .done(done_w)
  );

  assign OP_CLASS = op_reg;
  assign COUNT_SRC = cnt_src_reg;
  assign MEM_OPERAND = mem_reg;
  assign SEG_SELECT = seg_reg;
  assign ILLEGAL = ill_reg;
  assign CLOCKS = clk_reg;
  assign BUSY = busy_w;
  assign DONE = done_w;
  assign FLAGS_WE = fwe_reg;
  assign FLAGS_OUT = flags_reg;
  assign SP_ADJ_WE = spwe_reg;
  assign STACK_PTR_OUT = sp_reg;
  assign SMM_EXIT = smx_reg;

  AST_NEAR_RET_CLOCKS: assert property (@(posedge CLK) disable iff (!RST_N)
    take && INSN_OP == 8'hC3 |=> CLOCKS == ($past(PROT_MODE) ? 7'd26 : 7'd10))
    else $error("near return count wrong");
  AST_IMM_RET_SP: assert property (@(posedge CLK) disable iff (!RST_N)
    take && INSN_OP == 8'hC2 |=> SP_ADJ_WE && STACK_PTR_OUT ==
    $past(STACK_PTR_IN) + {16'h0000, $past(INSN_IMM16)}) else $error("stack adjust wrong");
  AST_FAR_MISS: assert property (@(posedge CLK) disable iff (!RST_N)
    take && INSN_OP == 8'hCA && PROT_MODE && !PRIV_CHANGE && CACHE_MISS
    |=> CLOCKS == 7'd27) else $error("far return miss count wrong");
  AST_PRIV_MISS: assert property (@(posedge CLK) disable iff (!RST_N)
    take && INSN_OP == 8'hCB && PROT_MODE && PRIV_CHANGE && CACHE_MISS
    |=> CLOCKS == 7'd72) else $error("privilege return count wrong");
  AST_ROL_REG: assert property (@(posedge CLK) disable iff (!RST_N)
    take && INSN_OP == 8'hD0 && INSN_MODRM[7:3] == 5'h18 |=> OP_CLASS == rrsd_pkg::RRSD_OP_ROL
    && CLOCKS == 7'd2 && BUSY && DONE ##1 !BUSY) else $error("rotate left decode wrong");
  AST_ROR_CNT_MISS: assert property (@(posedge CLK) disable iff (!RST_N)
    take && INSN_OP == 8'hD3 && INSN_MODRM[7:6] == 2'h0 && INSN_MODRM[5:3] == 3'h1
    && CACHE_MISS |=> CLOCKS == 7'd7) else $error("rotate right miss count wrong");
  AST_SAR_IMM: assert property (@(posedge CLK) disable iff (!RST_N)
    take && INSN_OP == 8'hC1 && INSN_MODRM[5:3] == 3'h7
    |=> COUNT_SRC == rrsd_pkg::RRSD_CNT_IMM && OP_CLASS == rrsd_pkg::RRSD_OP_SAR)
    else $error("immediate shift decode wrong");
  AST_RESTORE_SEG_SMM: assert property (@(posedge CLK) disable iff (!RST_N)
    take && INSN_OP == 8'h0F && INSN_OP2 == 8'h79 |=> ILLEGAL == !$past(SMM_ACTIVE))
    else $error("restore legality wrong");
  AST_LEAVE_SMM_BUSY: assert property (@(posedge CLK) disable iff (!RST_N)
    take && INSN_OP == 8'h0F && INSN_OP2 == 8'hAA |=> SMM_EXIT ##73 BUSY ##1 DONE ##1 !BUSY)
    else $error("leave management timing wrong");
  AST_FLAGS_KEEP: assert property (@(posedge CLK) disable iff (!RST_N)
    take && INSN_OP == 8'h9E |=> FLAGS_WE && FLAGS_OUT[5] == $past(FLAGS_IN[5])
    && FLAGS_OUT[7] == $past(ACC_HIGH_BYTE[7])) else $error("flag load wrong");
endmodule : rrsd_decoder
`default_nettype wire

/* File: dv/rrsd_fetch_model.sv */
/*
  holds: fetch-side model that hands whole instructions to the decoder.
  assumes: bench pulses req for one cycle with the packed bytes, on CLK.
*/
`timescale 1ns/100ps
`default_nettype none
module rrsd_fetch_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // request from bench: opcode, second byte, modrm, imm16
  input wire logic req,
  input wire logic [39:0] bytes,
  // decoder side
  input wire logic ready,
  output logic valid,
  output logic [39:0] insn,
  output logic taken
);
  // released bytes are inverted so a stale value is never mistaken for held data
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      valid <= 1'b0;
      insn <= 40'h0;
      taken <= 1'b0;
    end else begin
      taken <= valid && ready;
      if (valid && ready) begin
        valid <= 1'b0;
        insn <= ~insn;
      end else if (req && !valid) begin
        valid <= 1'b1;
        insn <= bytes;
      end
    end
  end
endmodule : rrsd_fetch_model
`default_nettype wire

/* File: dv/tb_top.sv */
/*
  holds: self-checking bench for the return/rotate/shift decoder.
  assumes: fetch model feeds the decoder; machine state driven here.
*/
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic clk, rst_n, req, ready, valid, taken, prot, miss, priv, system_management_state;
  logic mem_op, illegal, busy, done, flags_we, sp_we, smm_exit;
  logic cap_fwe, cap_swe, cap_sx, cap_ill, cap_mem;
  logic [39:0] bytes, insn;
  logic [7:0] acc, fin, flags_out, cap_f;
  logic [31:0] sp, sp_out, cap_sp;
  logic [2:0] seg, cap_seg;
  logic [6:0] clocks;
  rrsd_pkg::rrsd_op_t op_class;
  rrsd_pkg::rrsd_cnt_t cnt_src;
  int n_mismatch, compares, cyc;

  rrsd_fetch_model u_fetch (.clk(clk), .rst_n(rst_n), .req(req), .bytes(bytes),
    .ready(ready), .valid(valid), .insn(insn), .taken(taken));
  rrsd_decoder dut (.CLK(clk), .RST_N(rst_n), .INSN_VALID(valid),
    .INSN_OP(insn[39:32]), .INSN_OP2(insn[31:24]), .INSN_MODRM(insn[23:16]),
    .INSN_IMM16(insn[15:0]), .PROT_MODE(prot), .CACHE_MISS(miss), .PRIV_CHANGE(priv),
    .SMM_ACTIVE(system_management_state), .ACC_HIGH_BYTE(acc), .FLAGS_IN(fin), .STACK_PTR_IN(sp),
    .INSN_READY(ready), .OP_CLASS(op_class), .COUNT_SRC(cnt_src), .MEM_OPERAND(mem_op),
    .SEG_SELECT(seg), .ILLEGAL(illegal), .BUSY(busy), .DONE(done), .CLOCKS(clocks),
    .FLAGS_WE(flags_we), .FLAGS_OUT(flags_out), .SP_ADJ_WE(sp_we),
    .STACK_PTR_OUT(sp_out), .SMM_EXIT(smm_exit));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task test_done;
    $display("counts: compares=%0d mismatches=%0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : test_done

  // far beyond the several hundred cycles the tests need
  always @(posedge clk) begin
    cyc++;
    if (cyc == 8000) begin
      n_mismatch++;
      test_done;
    end
  end

  task chk(input logic ok, input string msg);
    compares++;
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask : chk

  task st(input logic p, input logic m, input logic v, input logic s);
    @(posedge clk);
    prot <= p;
    miss <= m;
    priv <= v;
    system_management_state <= s;
  endtask : st

  // one instruction; cycles counted from the take edge until ready again
  task run(input logic [39:0] b, input rrsd_pkg::rrsd_op_t ec,
           input rrsd_pkg::rrsd_cnt_t es, input int n);
    int k;
    @(posedge clk);
    req <= 1'b1;
    bytes <= b;
    @(posedge clk);
    req <= 1'b0;
    #1;
    k = 0;
    while (taken !== 1'b1 && k < 50) begin
      @(posedge clk);
      #1;
      k++;
    end
    chk(k < 50, "instruction never taken");
    {cap_fwe, cap_f, cap_swe, cap_sp} = {flags_we, flags_out, sp_we, sp_out};
    {cap_sx, cap_ill, cap_seg, cap_mem} = {smm_exit, illegal, seg, mem_op};
    chk(op_class === ec && cnt_src === es, "decode class");
    chk(clocks === n[6:0], "clock count");
    k = 1;
    while (busy === 1'b1 && k < 200) begin
      chk(done === (k == n - 1), "done position");
      @(posedge clk);
      #1;
      k++;
    end
    chk(k == n, "busy length");
  endtask : run

  task t_return;
    st(1'b0, 1'b0, 1'b0, 1'b0);
    run(40'hC300000000, rrsd_pkg::RRSD_OP_RETURN, rrsd_pkg::RRSD_CNT_NONE, 10);
    chk(cap_swe === 1'b0, "no stack adjust");
    run(40'hC200000014, rrsd_pkg::RRSD_OP_RETURN, rrsd_pkg::RRSD_CNT_NONE, 13);
    chk(cap_swe === 1'b1 && cap_sp === 32'h00010004, "stack adjust");
    st(1'b1, 1'b0, 1'b0, 1'b0);
    run(40'hC300000000, rrsd_pkg::RRSD_OP_RETURN, rrsd_pkg::RRSD_CNT_NONE, 26);
    run(40'hC200000014, rrsd_pkg::RRSD_OP_RETURN, rrsd_pkg::RRSD_CNT_NONE, 26);
    run(40'hCA00000014, rrsd_pkg::RRSD_OP_RETURN, rrsd_pkg::RRSD_CNT_NONE, 26);
    chk(cap_swe === 1'b1 && cap_sp === 32'h00010004, "far stack adjust");
    st(1'b1, 1'b1, 1'b0, 1'b0);
    run(40'hCA00000014, rrsd_pkg::RRSD_OP_RETURN, rrsd_pkg::RRSD_CNT_NONE, 27);
    st(1'b1, 1'b1, 1'b1, 1'b0);
    run(40'hCA00000014, rrsd_pkg::RRSD_OP_RETURN, rrsd_pkg::RRSD_CNT_NONE, 72);
    run(40'hCB00000000, rrsd_pkg::RRSD_OP_RETURN, rrsd_pkg::RRSD_CNT_NONE, 72);
    $display("test return done");
  endtask : t_return

  task t_shift;
    rrsd_pkg::rrsd_op_t cls[4];
    rrsd_pkg::rrsd_cnt_t cs;
    logic [2:0] fld[4];
    logic [7:0] op;
    logic [7:0] rm;
    int n;
    cls = '{rrsd_pkg::RRSD_OP_ROL, rrsd_pkg::RRSD_OP_ROR, rrsd_pkg::RRSD_OP_SAL,
            rrsd_pkg::RRSD_OP_SAR};
    fld = '{3'h0, 3'h1, 3'h4, 3'h7};
    for (int i = 0; i < 4; i++) begin
      // a miss must only lengthen memory forms
      st(i[0], i != 0, 1'b0, 1'b0);
      for (int m = 0; m < 2; m++) begin
        for (int f = 0; f < 3; f++) begin
          op = (f == 2) ? 8'hC0 : ((f == 1) ? 8'hD2 : 8'hD0);
          op[0] = i[0];
          cs = (f == 2) ? rrsd_pkg::RRSD_CNT_IMM : rrsd_pkg::RRSD_CNT_ONE;
          if (f == 1) cs = rrsd_pkg::RRSD_CNT_REG;
          n = (m == 0) ? 2 : ((i != 0) ? 6 : 4);
          n = n + ((f == 1) ? 1 : 0);
          rm = {(m == 1) ? 2'h0 : 2'h3, fld[i], 3'h1};
          run({op, 8'h00, rm, 16'h0000}, cls[i], cs, n);
          chk(cap_mem === m[0], "operand kind");
        end
      end
    end
    $display("test shift done");
  endtask : t_shift

  task t_restore;
    st(1'b0, 1'b0, 1'b0, 1'b1);
    run(40'h0F79280000, rrsd_pkg::RRSD_OP_RST_SEG, rrsd_pkg::RRSD_CNT_NONE, 14);
    chk(cap_seg === 3'h5 && cap_ill === 1'b0, "segment field");
    run(40'h0F78000000, rrsd_pkg::RRSD_OP_RST_LDT, rrsd_pkg::RRSD_CNT_NONE, 14);
    run(40'h0FAA000000, rrsd_pkg::RRSD_OP_LEAVE_SMM, rrsd_pkg::RRSD_CNT_NONE, 76);
    chk(cap_sx === 1'b1, "leave pulse");
    st(1'b1, 1'b0, 1'b0, 1'b1);
    run(40'h0F7D000000, rrsd_pkg::RRSD_OP_RST_TASK, rrsd_pkg::RRSD_CNT_NONE, 14);
    run(40'h0FAA000000, rrsd_pkg::RRSD_OP_LEAVE_SMM, rrsd_pkg::RRSD_CNT_NONE, 76);
    st(1'b1, 1'b0, 1'b0, 1'b0);
    run(40'h0F79280000, rrsd_pkg::RRSD_OP_RST_SEG, rrsd_pkg::RRSD_CNT_NONE, 1);
    chk(cap_ill === 1'b1, "restore outside management");
    $display("test restore done");
  endtask : t_restore

  task t_flags;
    @(posedge clk);
    acc <= 8'hFF;
    fin <= 8'h00;
    run(40'h9E00000000, rrsd_pkg::RRSD_OP_FLAGS_AH, rrsd_pkg::RRSD_CNT_NONE, 2);
    chk(cap_fwe === 1'b1 && cap_f === 8'hD5, "flags from ones");
    st(1'b0, 1'b0, 1'b0, 1'b0);
    acc <= 8'h00;
    fin <= 8'hFF;
    run(40'h9E00000000, rrsd_pkg::RRSD_OP_FLAGS_AH, rrsd_pkg::RRSD_CNT_NONE, 2);
    chk(cap_fwe === 1'b1 && cap_f === 8'h2A, "flags kept bits");
    // neighbouring opcode and an unused shift field must decode to nothing
    run(40'h9000000000, rrsd_pkg::RRSD_OP_NONE, rrsd_pkg::RRSD_CNT_NONE, 1);
    chk(cap_fwe === 1'b0, "no flag write");
    run(40'hD000D00000, rrsd_pkg::RRSD_OP_NONE, rrsd_pkg::RRSD_CNT_NONE, 1);
    $display("test flags done");
  endtask : t_flags

  initial begin
    {rst_n, req, prot, miss, priv, system_management_state} = 6'h0;
    {acc, fin, bytes} = 56'h0;
    sp = 32'h0000FFF0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1;
    chk(ready === 1'b1 && busy === 1'b0 && op_class === rrsd_pkg::RRSD_OP_NONE, "reset state");
    $display("test reset done");
    t_return;
    t_shift;
    t_restore;
    t_flags;
    test_done;
  end
endmodule : tb_top
`default_nettype wire
